// ==== hw/ssr_pkg.sv ====
// Shared constants for the sync source selection register bank
package ssr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SEL_W  = 4;

  // Register offsets
  localparam logic [7:0] ADDR_RSVD_A = 8'h1c;
  localparam logic [7:0] ADDR_RSVD_B = 8'h1d;
  localparam logic [7:0] ADDR_QCS    = 8'h1e;
  localparam logic [7:0] ADDR_MAS    = 8'h1f;
  localparam logic [7:0] ADDR_FDS    = 8'h20;
  localparam logic [7:0] ADDR_RSVD_C = 8'h21;

  // Reset values; reserved fields read back as these bits
  localparam logic [15:0] RESET_RSVD = 16'h0000;
  localparam logic [15:0] RESET_QCS  = 16'h1111;
  localparam logic [15:0] RESET_MAS  = 16'h1140;
  localparam logic [15:0] RESET_FDS  = 16'h2400;

  // Bits that software may change in each register
  localparam logic [15:0] WMASK_QCS = 16'hf0f0;
  localparam logic [15:0] WMASK_MAS = 16'hfffe;
  localparam logic [15:0] WMASK_FDS = 16'hff01;

  // Field positions
  localparam int POS_HI_SEL  = 12;
  localparam int POS_FIFOOUT = 8;
  localparam int POS_LO_SEL  = 4;
  localparam int POS_FMT     = 2;
  localparam int POS_SIF     = 1;
  localparam int POS_CLKDIV  = 0;

  // Source order inside every four-bit selection field
  localparam int SRC_SIF  = 3;
  localparam int SRC_EXT  = 2;
  localparam int SRC_OUTPUT_STROBE_INPUT = 1;
  localparam int SRC_LAST = 0;

  // Data formatter single-source codes; other codes disable the sync
  localparam logic [1:0] FMT_FRAME = 2'b00;
  localparam logic [1:0] FMT_EXT   = 2'b01;

  // Number of double-buffered groups: offset, correction, mixer
  localparam int NUM_GROUPS = 3;
  localparam int GRP_QOFF   = 0;
  localparam int GRP_QCORR  = 1;
  localparam int GRP_MIXER  = 2;

endpackage

// ==== hw/ssr_src_if.sv ====
// Synchronised sync sources shared by the double-buffer groups
interface ssr_src_if;
  logic sif;
  logic ext;
  logic output_strobe_input;
  logic frame;

  modport drive (output sif, output ext, output output_strobe_input, output frame);
  modport sink  (input sif, input ext, input output_strobe_input, input frame);
endinterface

// ==== hw/ssr_dbuf_group.sv ====
// One double-buffered group: shadow, active copy and its source selection
module ssr_dbuf_group
  import ssr_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  ssr_src_if.sink               src,
  input  wire logic [SEL_W-1:0] i_select,
  input  wire logic             i_shadow_wr,
  input  wire logic [W-1:0]     i_shadow_data,
  output logic      [W-1:0]     o_active,
  output logic                  o_sync
);

  typedef struct packed {
    logic [W-1:0] shadow;
    logic [W-1:0] active;
    logic         sync;
  } ssr_grp_t;

  ssr_grp_t state;
  ssr_grp_t next_state;
  logic     hit;

  // Auto-sync means the shadow write itself is a source
  assign hit = |(i_select & {src.sif, src.ext, src.output_strobe_input, i_shadow_wr});

  always_comb
  begin
    next_state = state;
    next_state.sync = hit;
    if (i_shadow_wr)
    begin
      next_state.shadow = i_shadow_data;
    end
    // Bypass so a write that is its own sync lands the new value
    if (hit)
    begin
      next_state.active = i_shadow_wr ? i_shadow_data : state.shadow;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_active = state.active;
  assign o_sync   = state.sync;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_hold_without_sync;
    !hit |=> $stable(o_active);
  endproperty
  a_hold_without_sync: assert property (p_hold_without_sync)
    else $error("active value changed without an enabled sync");

  property p_copy_on_sync;
    hit && !i_shadow_wr |=> o_active == $past(state.shadow);
  endproperty
  a_copy_on_sync: assert property (p_copy_on_sync)
    else $error("active value did not take the shadow on sync");

endmodule // ssr_dbuf_group

// ==== hw/ssr_sync_select_regs.sv ====
// Sync source selection register bank with its double-buffered groups
//
// Overview of operation
// - A four-bit any-combination field picks the sources for the offset group, resetting to auto-sync.
// - Each group selection field orders software sync, external sync, output strobe, then auto-sync, msb first.
// - Bits 7:4 of the same register pick the sources for the correction group, resetting to auto-sync.
// - Bits 15:12 of the mixer register pick the mixer group sources, resetting to auto-sync.
// - A four-bit field picks software, external, output strobe and frame to sync the accumulators.
// - The formatter takes one source by a two-bit code: frame, external, or none for the two others.
// - The software sync bit is a level source set and cleared by writes, zero after reset.
// - A four-bit field picks the FIFO input side sources, resetting to the output strobe.
// - The divider sync is the output strobe when its bit is 0, else the FIFO input selection less strobe.
// - After reset the mixer register reads 0x1140 and the correction register reads 0x1111.
module ssr_sync_select_regs
  import ssr_pkg::*;
#(
  parameter int GROUP_W = 16
)(
  input  wire logic                           i_core_clk,
  input  wire logic                           i_reset,
  input  wire logic [ADDR_W-1:0]              i_addr,
  input  wire logic [DATA_W-1:0]              i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [DATA_W-1:0]              o_rdata,
  input  wire logic                           i_ext_sync,
  input  wire logic                           i_output_strobe_input,
  input  wire logic                           i_frame_marker,
  input  wire logic [NUM_GROUPS-1:0]          i_shadow_wr,
  input  wire logic [NUM_GROUPS*GROUP_W-1:0]  i_shadow_data,
  output logic      [NUM_GROUPS*GROUP_W-1:0]  o_active,
  output logic      [NUM_GROUPS-1:0]          o_group_sync,
  output logic                                o_accum_sync,
  output logic                                o_formatter_sync,
  output logic                                o_fifo_in_sync,
  output logic                                o_clock_divider_sync,
  output logic      [SEL_W-1:0]               o_fifo_out_select
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [DATA_W-1:0] quad_sel;
    logic [DATA_W-1:0] mix_sel;
    logic [DATA_W-1:0] fifo_sel;
    logic [1:0]        ext_sync;
    logic [1:0]        output_strobe_input_sync;
    logic [1:0]        frame_sync;
    logic [DATA_W-1:0] rdata;
    logic              accum;
    logic              formatter;
    logic              fifo_in;
    logic              clk_div;
  } ssr_state_t;

  ssr_state_t state;
  ssr_state_t next_state;

  // Synchronised sources; only the second stage is ever read
  logic ext_s;
  logic output_strobe_input_s;
  logic frame_s;
  logic sif_s;

  logic [SEL_W-1:0] qoff_field;
  logic [SEL_W-1:0] qcorr_field;
  logic [SEL_W-1:0] mixer_field;
  logic [SEL_W-1:0] accum_field;
  logic [1:0]       fmt_field;
  logic [SEL_W-1:0] fifo_in_field;
  logic             clkdiv_field;
  logic [SEL_W-1:0] frame_sources;

  assign ext_s   = state.ext_sync[1];
  assign output_strobe_input_s  = state.output_strobe_input_sync[1];
  assign frame_s = state.frame_sync[1];
  assign sif_s   = state.mix_sel[POS_SIF];

  assign qoff_field    = state.quad_sel[POS_HI_SEL +: SEL_W];
  assign qcorr_field   = state.quad_sel[POS_LO_SEL +: SEL_W];
  assign mixer_field   = state.mix_sel[POS_HI_SEL +: SEL_W];
  assign accum_field   = state.mix_sel[POS_LO_SEL +: SEL_W];
  assign fmt_field     = state.mix_sel[POS_FMT +: 2];
  assign fifo_in_field = state.fifo_sel[POS_HI_SEL +: SEL_W];
  assign clkdiv_field  = state.fifo_sel[POS_CLKDIV];

  // Source vector for fields whose lowest bit is the frame marker
  assign frame_sources = {sif_s, ext_s, output_strobe_input_s, frame_s};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_state = state;

    next_state.ext_sync   = {state.ext_sync[0], i_ext_sync};
    next_state.output_strobe_input_sync  = {state.output_strobe_input_sync[0], i_output_strobe_input};
    next_state.frame_sync = {state.frame_sync[0], i_frame_marker};

    // Reserved bits are masked off so they always read their reset value
    if (i_wr)
    begin
      case (i_addr)
        ADDR_QCS:
        begin
          next_state.quad_sel = (state.quad_sel & ~WMASK_QCS) | (i_wdata & WMASK_QCS);
        end
        ADDR_MAS:
        begin
          next_state.mix_sel = (state.mix_sel & ~WMASK_MAS) | (i_wdata & WMASK_MAS);
        end
        ADDR_FDS:
        begin
          next_state.fifo_sel = (state.fifo_sel & ~WMASK_FDS) | (i_wdata & WMASK_FDS);
        end
        default:
        begin
          next_state.fifo_sel = state.fifo_sel;
        end
      endcase
    end

    // Read data stands for exactly one cycle; unmapped offsets read zero
    next_state.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_QCS:    next_state.rdata = state.quad_sel;
        ADDR_MAS:    next_state.rdata = state.mix_sel;
        ADDR_FDS:    next_state.rdata = state.fifo_sel;
        ADDR_RSVD_A: next_state.rdata = RESET_RSVD;
        ADDR_RSVD_B: next_state.rdata = RESET_RSVD;
        ADDR_RSVD_C: next_state.rdata = RESET_RSVD;
        default:     next_state.rdata = '0;
      endcase
    end

    next_state.accum   = |(accum_field & frame_sources);
    next_state.fifo_in = |(fifo_in_field & frame_sources);

    case (fmt_field)
      FMT_FRAME: next_state.formatter = frame_s;
      FMT_EXT:   next_state.formatter = ext_s;
      default:   next_state.formatter = 1'b0;
    endcase

    // Strobe bit of the FIFO field is not a divider source when bit set
    if (clkdiv_field)
    begin
      next_state.clk_div = |(fifo_in_field & frame_sources & ~(4'b0001 << SRC_OUTPUT_STROBE_INPUT));
    end
    else
    begin
      next_state.clk_div = output_strobe_input_s;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state          <= '0;
      state.quad_sel <= RESET_QCS;
      state.mix_sel  <= RESET_MAS;
      state.fifo_sel <= RESET_FDS;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Double-buffered groups

  ssr_src_if u_src ();

  assign u_src.sif   = sif_s;
  assign u_src.ext   = ext_s;
  assign u_src.output_strobe_input  = output_strobe_input_s;
  assign u_src.frame = frame_s;

  logic [SEL_W-1:0] group_select [NUM_GROUPS];

  assign group_select[GRP_QOFF]  = qoff_field;
  assign group_select[GRP_QCORR] = qcorr_field;
  assign group_select[GRP_MIXER] = mixer_field;

  generate
    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : g_group
      ssr_dbuf_group #(
        .W (GROUP_W)
      ) u_group (
        .i_core_clk    (i_core_clk),
        .i_reset       (i_reset),
        .src           (u_src.sink),
        .i_select      (group_select[g]),
        .i_shadow_wr   (i_shadow_wr[g]),
        .i_shadow_data (i_shadow_data[g*GROUP_W +: GROUP_W]),
        .o_active      (o_active[g*GROUP_W +: GROUP_W]),
        .o_sync        (o_group_sync[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata              = state.rdata;
  assign o_accum_sync         = state.accum;
  assign o_formatter_sync     = state.formatter;
  assign o_fifo_in_sync       = state.fifo_in;
  assign o_clock_divider_sync = state.clk_div;
  assign o_fifo_out_select    = state.fifo_sel[POS_FIFOOUT +: SEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_qoff_auto;
    qoff_field == 4'b0001 && i_shadow_wr[GRP_QOFF]
      |=> o_active[GRP_QOFF*GROUP_W +: GROUP_W]
          == $past(i_shadow_data[GRP_QOFF*GROUP_W +: GROUP_W]);
  endproperty
  a_qoff_auto: assert property (p_qoff_auto)
    else $error("offset group missed its auto-sync");

  property p_qcorr_ext;
    qcorr_field == 4'b0100 && ext_s && !i_shadow_wr[GRP_QCORR] |=> o_group_sync[GRP_QCORR];
  endproperty
  a_qcorr_ext: assert property (p_qcorr_ext)
    else $error("correction group ignored the external sync");

  property p_mixer_sif;
    mixer_field == 4'b1000 && !sif_s |=> !o_group_sync[GRP_MIXER];
  endproperty
  a_mixer_sif: assert property (p_mixer_sif)
    else $error("mixer group synced with its only source idle");

  property p_accum_frame;
    accum_field[SRC_LAST] && frame_s |=> o_accum_sync;
  endproperty
  a_accum_frame: assert property (p_accum_frame)
    else $error("accumulator sync missed the frame marker");

  property p_formatter_off;
    fmt_field[1] |=> !o_formatter_sync;
  endproperty
  a_formatter_off: assert property (p_formatter_off)
    else $error("formatter synced while disabled");

  property p_sif_write;
    i_wr && i_addr == ADDR_MAS ##1 !(i_wr && i_addr == ADDR_MAS)[*2]
      |-> sif_s == $past(i_wdata[POS_SIF], 2);
  endproperty
  a_sif_write: assert property (p_sif_write)
    else $error("software sync bit does not hold the written level");

  property p_fifo_in_output_strobe_input;
    fifo_in_field == 4'b0010 |=> o_fifo_in_sync == $past(output_strobe_input_s);
  endproperty
  a_fifo_in_output_strobe_input: assert property (p_fifo_in_output_strobe_input)
    else $error("fifo input sync does not follow the strobe");

  property p_clkdiv_select;
    clkdiv_field && fifo_in_field == 4'b0010 |=> !o_clock_divider_sync;
  endproperty
  a_clkdiv_select: assert property (p_clkdiv_select)
    else $error("divider sync used the strobe when it must not");

  property p_reset_reads;
    $fell(i_reset) ##0 (i_rd && i_addr == ADDR_MAS) |=> o_rdata == RESET_MAS;
  endproperty
  a_reset_reads: assert property (p_reset_reads)
    else $error("mixer register does not read its reset value");

  property p_read_one_cycle;
    !i_rd |=> o_rdata == '0;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data stood outside its cycle");

  property p_qcorr_idle;
    qcorr_field == 4'b0000 |=> !o_group_sync[GRP_QCORR];
  endproperty
  a_qcorr_idle: assert property (p_qcorr_idle)
    else $error("correction group synced with no source enabled");

  property p_qoff_ext;
    qoff_field[SRC_EXT] && ext_s |=> o_group_sync[GRP_QOFF];
  endproperty
  a_qoff_ext: assert property (p_qoff_ext)
    else $error("offset group ignored the external sync");

  property p_mixer_auto;
    mixer_field[SRC_LAST] && i_shadow_wr[GRP_MIXER] |=> o_group_sync[GRP_MIXER];
  endproperty
  a_mixer_auto: assert property (p_mixer_auto)
    else $error("mixer group missed its auto-sync");

  property p_accum_ext;
    accum_field == 4'b0100 |=> o_accum_sync == $past(ext_s);
  endproperty
  a_accum_ext: assert property (p_accum_ext)
    else $error("accumulator sync does not follow the external sync");

  property p_formatter_frame;
    fmt_field == FMT_FRAME |=> o_formatter_sync == $past(frame_s);
  endproperty
  a_formatter_frame: assert property (p_formatter_frame)
    else $error("formatter sync does not follow the frame marker");

  property p_formatter_ext;
    fmt_field == FMT_EXT |=> o_formatter_sync == $past(ext_s);
  endproperty
  a_formatter_ext: assert property (p_formatter_ext)
    else $error("formatter sync does not follow the external sync");

  property p_sif_reset;
    $fell(i_reset) |-> !sif_s;
  endproperty
  a_sif_reset: assert property (p_sif_reset)
    else $error("software sync bit is set after reset");

  property p_fifo_in_sif;
    fifo_in_field[SRC_SIF] && sif_s |=> o_fifo_in_sync;
  endproperty
  a_fifo_in_sif: assert property (p_fifo_in_sif)
    else $error("fifo input sync ignored the software sync");

  property p_clkdiv_output_strobe_input;
    !clkdiv_field |=> o_clock_divider_sync == $past(output_strobe_input_s);
  endproperty
  a_clkdiv_output_strobe_input: assert property (p_clkdiv_output_strobe_input)
    else $error("divider sync does not follow the strobe");

  property p_reserved_read;
    i_rd && i_addr == ADDR_RSVD_C |=> o_rdata == RESET_RSVD;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved register read back nonzero");

endmodule // ssr_sync_select_regs

// ==== tb/tb_top.sv ====
// Self-checking testbench for the sync source selection register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ssr_pkg::*;

  logic                          i_core_clk;
  logic                          i_reset;
  logic [ADDR_W-1:0]             i_addr;
  logic [DATA_W-1:0]             i_wdata;
  logic                          i_wr;
  logic                          i_rd;
  logic [DATA_W-1:0]             o_rdata;
  logic                          i_ext_sync;
  logic                          i_output_strobe_input;
  logic                          i_frame_marker;
  logic [NUM_GROUPS-1:0]         i_shadow_wr;
  logic [NUM_GROUPS*16-1:0]      i_shadow_data;
  logic [NUM_GROUPS*16-1:0]      o_active;
  logic [NUM_GROUPS-1:0]         o_group_sync;
  logic                          o_accum_sync;
  logic                          o_formatter_sync;
  logic                          o_fifo_in_sync;
  logic                          o_clock_divider_sync;
  logic [SEL_W-1:0]              o_fifo_out_select;
  int                            err_count;
  int                            compares;

  ssr_sync_select_regs #(.GROUP_W(16)) i_ssr_sync_select_regs (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_sync(i_ext_sync),
    .i_output_strobe_input(i_output_strobe_input), .i_frame_marker(i_frame_marker),
    .i_shadow_wr(i_shadow_wr), .i_shadow_data(i_shadow_data), .o_active(o_active),
    .o_group_sync(o_group_sync), .o_accum_sync(o_accum_sync),
    .o_formatter_sync(o_formatter_sync), .o_fifo_in_sync(o_fifo_in_sync),
    .o_clock_divider_sync(o_clock_divider_sync), .o_fifo_out_select(o_fifo_out_select));

  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    chk_word(o_rdata, exp);
  endtask

  task automatic shadow(input int g, input logic [15:0] d, input logic [15:0] exp,
                        input logic exp_sync);
    @(posedge i_core_clk);
    i_shadow_wr[g]            <= 1'b1;
    i_shadow_data[g*16 +: 16] <= d;
    @(posedge i_core_clk);
    i_shadow_wr               <= 3'b000;
    @(negedge i_core_clk);
    chk_word(o_active[g*16 +: 16], exp);
    chk_flags({7'h00, o_group_sync[g]}, {7'h00, exp_sync});
  endtask

  // Expected sync levels once pins and registers have settled
  function automatic logic [7:0] exp_lv(input logic [15:0] q, input logic [15:0] m,
                                        input logic [15:0] f, input logic [2:0] p);
    logic [3:0] s;
    logic       fmt;
    s   = {m[1], p};
    fmt = (m[3:2] == FMT_FRAME) ? s[0] : ((m[3:2] == FMT_EXT) ? s[2] : 1'b0);
    return {1'b0, |(m[15:12] & {s[3:1], 1'b0}), |(q[7:4] & {s[3:1], 1'b0}),
            |(q[15:12] & {s[3:1], 1'b0}), |(m[7:4] & s), fmt, |(f[15:12] & s),
            f[0] ? |(f[15:12] & {s[3:2], 1'b0, s[0]}) : s[1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // First read rides on the release edge, the earliest legal request
  task automatic t_reset_values;
    i_rd   <= 1'b1;
    i_addr <= ADDR_MAS;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    chk_word(o_rdata, 16'h1140);
    reg_rd(ADDR_QCS, 16'h1111);
    reg_rd(ADDR_MAS, 16'h1140);
    reg_rd(ADDR_FDS, 16'h2400);
    chk_word({12'h000, o_fifo_out_select}, 16'h0004);
  endtask

  task automatic t_reserved;
    logic [7:0] addrs [4];
    addrs = '{ADDR_RSVD_A, ADDR_RSVD_B, ADDR_RSVD_C, 8'h30};
    foreach (addrs[i])
    begin
      reg_wr(addrs[i], 16'hffff);
      reg_rd(addrs[i], 16'h0000);
    end
  endtask

  // Every group resets to auto-sync, so a shadow write lands at once
  task automatic t_auto_sync;
    shadow(0, 16'h1234, 16'h1234, 1'b1);
    shadow(1, 16'h5678, 16'h5678, 1'b1);
    shadow(2, 16'h9abc, 16'h9abc, 1'b1);
  endtask

  task automatic t_pin_group;
    int n;
    reg_wr(ADDR_QCS, 16'h4000);
    shadow(0, 16'ha5a5, 16'h1234, 1'b0);
    shadow(1, 16'h0f0f, 16'h5678, 1'b0);
    @(posedge i_core_clk);
    i_ext_sync <= 1'b1;
    n = 0;
    while (o_group_sync[0] !== 1'b1)
    begin
      @(negedge i_core_clk);
      n++;
      if (n > 20)
      begin
        err_count++;
        $display("ERROR t=%0t group sync wait got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
      end
    end
    chk_word(o_active[15:0], 16'ha5a5);
    chk_word(o_active[31:16], 16'h5678);
    @(posedge i_core_clk);
    i_ext_sync <= 1'b0;
  endtask

  // Register sets chosen to cover every formatter code and both divider modes
  task automatic t_level_sets;
    logic [15:0] q [4];
    logic [15:0] m [4];
    logic [15:0] f [4];
    logic [2:0]  p;
    q = '{16'h8050, 16'h2010, 16'h1010, 16'h6040};
    m = '{16'h2156, 16'h81a8, 16'h114c, 16'h4170};
    f = '{16'hd401, 16'h5400, 16'h2501, 16'h9800};
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(ADDR_QCS, q[k]);
      reg_wr(ADDR_MAS, m[k]);
      reg_wr(ADDR_FDS, f[k]);
      reg_rd(ADDR_QCS, (q[k] & WMASK_QCS) | (RESET_QCS & ~WMASK_QCS));
      reg_rd(ADDR_MAS, (m[k] & WMASK_MAS) | (RESET_MAS & ~WMASK_MAS));
      reg_rd(ADDR_FDS, (f[k] & WMASK_FDS) | (RESET_FDS & ~WMASK_FDS));
      chk_word({12'h000, o_fifo_out_select}, {12'h000, f[k][11:8]});
      for (int v = 0; v < 8; v++)
      begin
        p = v[2:0];
        @(posedge i_core_clk);
        {i_ext_sync, i_output_strobe_input, i_frame_marker} <= p;
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk_flags({1'b0, o_group_sync[2], o_group_sync[1], o_group_sync[0], o_accum_sync,
                   o_formatter_sync, o_fifo_in_sync, o_clock_divider_sync},
                  exp_lv(q[k], m[k], f[k], p));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_count             = 0;
    compares              = 0;
    i_reset               = 1'b1;
    i_addr                = 8'h00;
    i_wdata               = 16'h0000;
    i_wr                  = 1'b0;
    i_rd                  = 1'b0;
    i_ext_sync            = 1'b0;
    i_output_strobe_input = 1'b0;
    i_frame_marker        = 1'b0;
    i_shadow_wr           = 3'b000;
    i_shadow_data         = '0;
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_reset_values();
    t_reserved();
    t_auto_sync();
    t_pin_group();
    t_level_sets();
    conclude();
  end

endmodule // tb_top
